// ==== include/aimt_regs.svh ====
// Register offsets, field positions, reset values and widths of the mask and target block
`ifndef AIMT_REGS_SVH
`define AIMT_REGS_SVH

`define AIMT_OFF_W 8
`define AIMT_OFF_MASK 8'h14
`define AIMT_OFF_TARGET 8'h18

`define AIMT_SRC_N 6
`define AIMT_BIT_READ_PARITY 0
`define AIMT_BIT_B_CMDADDR_PARITY 1
`define AIMT_BIT_B_DATA_PARITY 2
`define AIMT_BIT_A_CMDADDR_PARITY 3
`define AIMT_BIT_A_DATA_PARITY 4
`define AIMT_BIT_POWER_FAIL 5

`define AIMT_DEST_LSB 0
`define AIMT_DEST_MSB 15
`define AIMT_NODES 16

`define AIMT_MASK_RESET 6'h00
`define AIMT_TARGET_RESET 32'h0000_0000

`endif

// ==== include/aimt_pkg.sv ====
// Types shared by the mask and target block
package aimt_pkg;
    typedef logic [7:0] aimt_off_t;
    typedef logic [31:0] aimt_word_t;
    typedef logic [5:0] aimt_src_t;
    typedef enum logic [0:0] {IV_IDLE, IV_REQ} aimt_iv_state_t;
endpackage

// ==== include/aimt_src_if.sv ====
// Carrier between the register core and the interrupt gate
`timescale 1ns/1ps
interface aimt_src_if;
    logic [5:0] mask;
    logic [5:0] status;
    logic [5:0] hits;
    logic irq;
    modport core (output mask, output status, input hits, input irq);
    modport gate (input mask, input status, output hits, output irq);
endinterface

// ==== rtl/aimt_irq_gate.sv ====
// Per-source gating of error status by the interrupt mask
`timescale 1ns/1ps
module aimt_irq_gate #(
    parameter int SRC_N = 6
) (
    // Mask and status in, gated request out
    aimt_src_if.gate src
);
    generate
        if (SRC_N != 6) begin : g_bad
            $error("aimt_irq_gate serves exactly six sources");
        end
        for (genvar i = 0; i < SRC_N; i++) begin : g_src
            assign src.hits[i] = src.mask[i] & src.status[i];
        end
    endgenerate
    assign src.irq = |src.hits;
endmodule

// ==== rtl/aimt_core.sv ====
// Interrupt mask and implied-vector target registers of the adapter
//
// Function
// - With mask bit 5 set, a set power-fail status bit raises the interrupt.
// - With mask bit 4 set, a channel A data parity flag raises the interrupt.
// - With mask bit 3 set, a channel A command/address parity flag raises the interrupt.
// - With mask bit 2 set, a channel B data parity flag raises the interrupt.
// - With mask bit 1 set, a channel B command/address parity flag raises the interrupt.
// - With mask bit 0 set, a read data parity status bit raises the interrupt.
// - The target register answers at offset 0x18 of the node space.
// - Target bits 15 to 0 are a destination mask, bit n selecting node n.
// - An implied-vector interrupt goes to the nodes whose destination bits are set.
// - Any nonzero mix of destination bits is taken, all chosen nodes share one transaction.
// - All 32 target bits write and read back unchanged for data path checks.
`timescale 1ns/1ps
`include "aimt_regs.svh"
module aimt_core #(
    parameter int NODES = `AIMT_NODES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Node-space register access
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire aimt_pkg::aimt_off_t reg_offset,
    input wire aimt_pkg::aimt_word_t reg_wdata,
    output aimt_pkg::aimt_word_t reg_rdata,
    output logic reg_ack,
    // Error status from the adapter
    input wire aimt_pkg::aimt_src_t error_status_reg,
    // Interrupt request and implied-vector transaction
    output logic irq,
    output logic iv_req,
    output logic [NODES-1:0] iv_dest,
    input wire logic iv_ack
);
    import aimt_pkg::*;

    generate
        if (NODES < 1 || NODES > 16) begin : g_bad_nodes
            $error("aimt_core serves one to sixteen nodes");
        end
    endgenerate

    aimt_src_t interrupt_mask_reg;
    aimt_word_t implied_vector_target_reg;
    aimt_iv_state_t iv_state;
    logic irq_seen;
    logic iv_pend;
    logic wr_mask;
    logic wr_target;
    logic irq_rise;
    logic [NODES-1:0] dest_field;

    aimt_src_if src ();

    // Gate instance
    aimt_irq_gate #(
        .SRC_N(`AIMT_SRC_N)
    ) u_gate (
        .src(src)
    );

    assign src.mask = interrupt_mask_reg;
    assign src.status = error_status_reg;

    // Address decode
    assign wr_mask = reg_sel && reg_wr && reg_offset == `AIMT_OFF_MASK;
    assign wr_target = reg_sel && reg_wr && reg_offset == `AIMT_OFF_TARGET;
    assign dest_field = implied_vector_target_reg[NODES-1:0];

    // Mask register
    always_ff @(posedge clock) begin
        if (rst) begin
            interrupt_mask_reg <= `AIMT_MASK_RESET;
        end else if (wr_mask) begin
            interrupt_mask_reg <= reg_wdata[`AIMT_SRC_N-1:0];
        end
    end

    // Target register, all 32 bits kept
    always_ff @(posedge clock) begin
        if (rst) begin
            implied_vector_target_reg <= `AIMT_TARGET_RESET;
        end else if (wr_target) begin
            implied_vector_target_reg <= reg_wdata;
        end
    end

    // Read data and acknowledge
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_sel && (reg_rd || reg_wr);
            if (reg_sel && reg_rd) begin
                case (reg_offset)
                    `AIMT_OFF_MASK: reg_rdata <= {26'h0, interrupt_mask_reg};
                    `AIMT_OFF_TARGET: reg_rdata <= implied_vector_target_reg;
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Interrupt request
    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
            irq_seen <= 1'b0;
        end else begin
            irq <= src.irq;
            irq_seen <= irq;
        end
    end

    assign irq_rise = irq && !irq_seen;

    // Implied-vector transaction sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            iv_state <= IV_IDLE;
            iv_req <= 1'b0;
            iv_dest <= '0;
            iv_pend <= 1'b0;
        end else begin
            case (iv_state)
                IV_IDLE: begin
                    if ((irq_rise || iv_pend) && dest_field != '0) begin
                        iv_state <= IV_REQ;
                        iv_req <= 1'b1;
                        iv_dest <= dest_field;
                        iv_pend <= 1'b0;
                    end else begin
                        iv_pend <= 1'b0;
                    end
                end
                IV_REQ: begin
                    if (irq_rise) begin
                        iv_pend <= 1'b1;
                    end
                    if (iv_ack) begin
                        iv_state <= IV_IDLE;
                        iv_req <= 1'b0;
                    end
                end
                default: begin
                    iv_state <= IV_IDLE;
                    iv_req <= 1'b0;
                end
            endcase
        end
    end

    // Checks
    AST_POWER_FAIL: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_reg[`AIMT_BIT_POWER_FAIL] && error_status_reg[`AIMT_BIT_POWER_FAIL] |=> irq)
        else $error("power-fail event did not raise the interrupt");

    AST_A_DATA_PARITY: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_reg[`AIMT_BIT_A_DATA_PARITY] && error_status_reg[`AIMT_BIT_A_DATA_PARITY] |=> irq)
        else $error("channel A data parity did not raise the interrupt");

    AST_A_CMDADDR_PARITY: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_reg[`AIMT_BIT_A_CMDADDR_PARITY] && error_status_reg[`AIMT_BIT_A_CMDADDR_PARITY] |=> irq)
        else $error("channel A cmd/addr parity did not raise the interrupt");

    AST_B_DATA_PARITY: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_reg[`AIMT_BIT_B_DATA_PARITY] && error_status_reg[`AIMT_BIT_B_DATA_PARITY] |=> irq)
        else $error("channel B data parity did not raise the interrupt");

    AST_B_CMDADDR_PARITY: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_reg[`AIMT_BIT_B_CMDADDR_PARITY] && error_status_reg[`AIMT_BIT_B_CMDADDR_PARITY] |=> irq)
        else $error("channel B cmd/addr parity did not raise the interrupt");

    AST_READ_PARITY: assert property (@(posedge clock) disable iff (rst)
        interrupt_mask_reg[`AIMT_BIT_READ_PARITY] && error_status_reg[`AIMT_BIT_READ_PARITY] |=> irq)
        else $error("read data parity did not raise the interrupt");

    AST_MASKED_QUIET: assert property (@(posedge clock) disable iff (rst)
        (interrupt_mask_reg & error_status_reg) == 6'h00 |=> !irq)
        else $error("interrupt raised with no unmasked status");

    AST_TARGET_DECODE: assert property (@(posedge clock) disable iff (rst)
        reg_sel && reg_rd && reg_offset == `AIMT_OFF_TARGET
        |=> reg_ack && reg_rdata == $past(implied_vector_target_reg))
        else $error("target register did not answer at its offset");

    AST_TARGET_READBACK: assert property (@(posedge clock) disable iff (rst)
        reg_sel && reg_wr && reg_offset == `AIMT_OFF_TARGET
        ##1 reg_sel && reg_rd && reg_offset == `AIMT_OFF_TARGET && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("target register did not read back what was written");

    AST_DEST_FIELD: assert property (@(posedge clock) disable iff (rst)
        $rose(iv_req) |-> iv_dest == $past(implied_vector_target_reg[NODES-1:0]))
        else $error("transaction destination differs from target field");

    AST_DEST_HELD: assert property (@(posedge clock) disable iff (rst)
        iv_req && !iv_ack |=> iv_req && $stable(iv_dest))
        else $error("transaction dropped or destination changed before acknowledge");

    AST_IV_START: assert property (@(posedge clock) disable iff (rst)
        irq_rise && iv_state == IV_IDLE && dest_field != '0 |=> iv_req)
        else $error("interrupt rise did not start a transaction");

    AST_RESET_ZERO: assert property (@(posedge clock)
        rst |=> interrupt_mask_reg == 6'h00 && implied_vector_target_reg == 32'h0000_0000 && !iv_req)
        else $error("registers not zero after reset");

    AST_ACK_ANSWER: assert property (@(posedge clock) disable iff (rst)
        reg_sel && (reg_rd || reg_wr) |=> reg_ack)
        else $error("access was not acknowledged");

    AST_ACK_PULSE: assert property (@(posedge clock) disable iff (rst)
        !(reg_sel && (reg_rd || reg_wr)) |=> !reg_ack)
        else $error("acknowledge without an access");

    AST_MASK_WRITE: assert property (@(posedge clock) disable iff (rst)
        wr_mask |=> interrupt_mask_reg == $past(reg_wdata[`AIMT_SRC_N-1:0]))
        else $error("mask write did not land");

    AST_MASK_HOLD: assert property (@(posedge clock) disable iff (rst)
        !wr_mask |=> $stable(interrupt_mask_reg))
        else $error("mask changed without a write");

    AST_MASK_READ: assert property (@(posedge clock) disable iff (rst)
        reg_sel && reg_rd && reg_offset == `AIMT_OFF_MASK |=> reg_rdata == {26'h0, $past(interrupt_mask_reg)})
        else $error("mask read returned wrong data");

    AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (rst)
        reg_sel && reg_rd && reg_offset != `AIMT_OFF_MASK && reg_offset != `AIMT_OFF_TARGET
        |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    AST_TARGET_WRITE: assert property (@(posedge clock) disable iff (rst)
        wr_target |=> implied_vector_target_reg == $past(reg_wdata))
        else $error("target write did not land");

    AST_TARGET_UPPER_KEPT: assert property (@(posedge clock) disable iff (rst)
        wr_target |=> implied_vector_target_reg[31:16] == $past(reg_wdata[31:16]))
        else $error("target upper half not kept");

    AST_TARGET_HOLD: assert property (@(posedge clock) disable iff (rst)
        !wr_target |=> $stable(implied_vector_target_reg))
        else $error("target changed without a write");

    AST_RDATA_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(reg_sel && reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> irq == $past(|(interrupt_mask_reg & error_status_reg)))
        else $error("interrupt differs from unmasked status");

    AST_RESET_OUTPUTS: assert property (@(posedge clock)
        rst |=> !irq && !reg_ack && reg_rdata == 32'h0000_0000 && iv_dest == '0)
        else $error("outputs not idle after reset");

    AST_REQ_CAUSE: assert property (@(posedge clock) disable iff (rst)
        $rose(iv_req) |-> $past(irq_rise || iv_pend))
        else $error("transaction started without an interrupt rise");

    AST_NO_SPURIOUS_REQ: assert property (@(posedge clock) disable iff (rst)
        !iv_req && !irq_rise && !iv_pend |=> !iv_req)
        else $error("transaction started with nothing to send");

    AST_DEST_NONZERO: assert property (@(posedge clock) disable iff (rst)
        iv_req |-> iv_dest != '0)
        else $error("transaction with an empty destination");

    AST_ZERO_DEST_SKIP: assert property (@(posedge clock) disable iff (rst)
        iv_state == IV_IDLE && dest_field == '0 |=> !iv_req)
        else $error("transaction started with zero destination field");

    AST_ACK_ENDS: assert property (@(posedge clock) disable iff (rst)
        iv_req && iv_ack |=> !iv_req)
        else $error("transaction not ended by acknowledge");

    AST_PEND_SET: assert property (@(posedge clock) disable iff (rst)
        iv_state == IV_REQ && irq_rise |=> iv_pend)
        else $error("rise during a transaction was lost");

    AST_PEND_HOLD: assert property (@(posedge clock) disable iff (rst)
        iv_state == IV_REQ && iv_pend |=> iv_pend)
        else $error("remembered rise dropped while busy");

    AST_PEND_REISSUE: assert property (@(posedge clock) disable iff (rst)
        iv_pend && iv_state == IV_IDLE && dest_field != '0 |=> iv_req)
        else $error("remembered rise was not reissued");

    AST_PEND_DROP: assert property (@(posedge clock) disable iff (rst)
        iv_state == IV_IDLE |=> !iv_pend)
        else $error("remembered rise kept after idle");

    COV_MULTI_NODE: cover property (@(posedge clock) disable iff (rst)
        $rose(iv_req) && !$onehot(iv_dest));
    COV_PEND_REISSUE: cover property (@(posedge clock) disable iff (rst)
        iv_req && iv_ack && iv_pend ##1 !iv_req ##1 iv_req);
    COV_DIAG_UPPER: cover property (@(posedge clock) disable iff (rst)
        wr_target && reg_wdata[31:16] != 16'h0000);
    COV_ALL_SOURCES: cover property (@(posedge clock) disable iff (rst)
        (interrupt_mask_reg & error_status_reg) == 6'h3F);
    COV_ZERO_DEST: cover property (@(posedge clock) disable iff (rst)
        irq_rise && iv_state == IV_IDLE && dest_field == '0);
endmodule

// ==== dv/aimt_node_model.sv ====
// Behavioural system-bus node that answers implied-vector transactions
`timescale 1ns/1ps
module aimt_node_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Transaction request, answer delay and answer
    input wire logic iv_req,
    input wire logic [15:0] iv_dest,
    input wire logic [3:0] dly,
    output logic iv_ack,
    output logic [15:0] got_dest,
    output logic [7:0] served
);
    logic [3:0] cnt;

    // Any destination mix is one transaction, answered dly+1 cycles after the request
    always @(posedge clock) begin
        if (rst) begin
            iv_ack <= 1'b0;
            cnt <= 4'h0;
            served <= 8'h00;
            got_dest <= 16'h0000;
        end else if (iv_req && !iv_ack && cnt >= dly) begin
            iv_ack <= 1'b1;
            got_dest <= iv_dest;
            served <= served + 8'h01;
            cnt <= 4'h0;
        end else begin
            iv_ack <= 1'b0;
            cnt <= (iv_req && !iv_ack) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ==== dv/aimt_tb_top.sv ====
// Self-checking bench of the mask and target registers
`timescale 1ns/1ps
`include "aimt_regs.svh"
module aimt_tb_top;
    import aimt_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_sel = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    aimt_off_t reg_offset = 8'h00;
    aimt_word_t reg_wdata = 32'h0000_0000;
    aimt_word_t reg_rdata;
    aimt_src_t status = 6'h00;
    logic reg_ack, irq, iv_req, iv_ack;
    logic [15:0] iv_dest, got_dest;
    logic [7:0] served, n;
    logic [3:0] dly = 4'h0;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;

    always #25 clock = ~clock;

    aimt_core #(.NODES(16)) i_dut (.clock(clock), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .error_status_reg(status), .irq(irq), .iv_req(iv_req),
        .iv_dest(iv_dest), .iv_ack(iv_ack));
    aimt_node_model i_node (.clock(clock), .rst(rst), .iv_req(iv_req), .iv_dest(iv_dest),
        .dly(dly), .iv_ack(iv_ack), .got_dest(got_dest), .served(served));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic access(input logic w, input aimt_off_t off, input aimt_word_t d);
        @(negedge clock);
        reg_sel = 1'b1;
        reg_wr = w;
        reg_rd = !w;
        reg_offset = off;
        reg_wdata = d;
        @(negedge clock);
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmp(reg_ack, 32'h1, "ack");
    endtask

    task automatic rd(input aimt_off_t off, input aimt_word_t exp);
        access(1'b0, off, 32'h0000_0000);
        cmp(reg_rdata, exp, "read");
    endtask

    task automatic wr_rd(input aimt_word_t d);
        @(negedge clock);
        reg_sel = 1'b1;
        reg_wr = 1'b1;
        reg_rd = 1'b0;
        reg_offset = `AIMT_OFF_TARGET;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        cmp(reg_ack, 32'h1, "write ack");
        @(negedge clock);
        reg_sel = 1'b0;
        reg_rd = 1'b0;
        cmp(reg_ack, 32'h1, "read ack");
        cmp(reg_rdata, d, "back-to-back read");
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        rd(`AIMT_OFF_MASK, 32'h0000_0000);
        rd(`AIMT_OFF_TARGET, 32'h0000_0000);
        access(1'b1, `AIMT_OFF_TARGET, 32'hA5C3_3C5A);
        rd(`AIMT_OFF_TARGET, 32'hA5C3_3C5A);
        wr_rd(32'h5A5A_F00F);
        access(1'b1, `AIMT_OFF_MASK, 32'hFFFF_FFFF);
        rd(`AIMT_OFF_MASK, 32'h0000_003F);
        rd(8'h1C, 32'h0000_0000);
        $display("registers test done");
        access(1'b1, `AIMT_OFF_TARGET, 32'h0000_9025);
        for (int i = 0; i < 6; i++) begin
            access(1'b1, `AIMT_OFF_MASK, 32'h1 << i);
            status = 6'h3F ^ (6'h01 << i);
            repeat (3) @(negedge clock);
            cmp(irq, 32'h0, "masked irq");
            n = served;
            dly = 4'(i);
            status = 6'h3F;
            @(negedge clock);
            cmp(irq, 32'h1, "irq");
            repeat (14) if (served == n) @(negedge clock);
            cmp(served, n + 8'h01, "transactions");
            cmp(got_dest, 32'h0000_9025, "dest");
            status = 6'h00;
            repeat (2) @(negedge clock);
            cmp(irq, 32'h0, "irq drop");
        end
        $display("interrupt test done");
        n = served;
        dly = 4'hF;
        status = 6'h20;
        repeat (2) @(negedge clock);
        status = 6'h00;
        repeat (2) @(negedge clock);
        status = 6'h20;
        repeat (60) if (served != n + 8'h02) @(negedge clock);
        cmp(served, n + 8'h02, "reissue");
        repeat (20) @(negedge clock);
        cmp(served, n + 8'h02, "single reissue");
        cmp(got_dest, 32'h0000_9025, "reissue dest");
        status = 6'h00;
        $display("reissue test done");
        access(1'b1, `AIMT_OFF_TARGET, 32'h0000_0000);
        n = served;
        status = 6'h20;
        repeat (8) @(negedge clock);
        cmp(served, n, "no destination");
        cmp(irq, 32'h1, "irq without destination");
        $display("empty destination test done");
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        cmp(irq, 32'h0, "reset irq");
        rd(`AIMT_OFF_MASK, 32'h0000_0000);
        rd(`AIMT_OFF_TARGET, 32'h0000_0000);
        cmp(irq, 32'h0, "masked after reset");
        status = 6'h00;
        $display("mid-run reset test done");
        close_out();
    end
endmodule
